// *** rtl/ocd_channel_ctrl.sv ***
// per-channel wide delay, power-down, clock/sysref select and bias control
// assumes a 4-wire serial config port, SCLK at most CLK/6, pins asynchronous
//
// Contract
// R1 - wide delay equals the 9-bit code times 127 ps, 512 steps
// R2 - code zero gives no delay; all ones gives 64.977 ns
// R3 - software keeps the wide delay stage input at or below 4 GHz
// R4 - power-down bit 0 runs the channel, 1 stops outputs, divider, delay; resets 0 (CH_DIV_RATIO keeps showing the ratio while powered down)
// R5 - channel power-down overrides every individual output power-down
// R6 - software sets the low-supply flag for 700 mV outputs on 1.8 V supply
// R7 - retime step bit acts only on sysref channels, never on clock channels
// R8 - software clears retime step bit unless external oscillator below 2 GHz
// R9 - retime bit clear: fine step is one oscillator period, 254 ps
// R10 - retime bit clear: only codes 4n and 4n+1 valid
// R11 - retime bit set: every code valid, step is half an oscillator period
// R12 - select 0 makes a divided clock channel, 1 a sysref channel
// R13 - bias type 0 idles sysref low, 1 at cross point; default 1
// R14 - force 0 toggles during an event, 1 holds the bias level
// R15 - bias controls exist only on lvds channels, absent on C and D
// R16 - C/D bypass 0 uses channel path, 1 buffers external oscillator undivided
// R17 - divider is stage one (1..5) times power of two; stage one 000 bypasses
`timescale 1ns/1ps
module ocd_channel_ctrl
  import ocd_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int NOUT = NOUT_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // serial configuration port
  input wire logic SPI_CS_N,
  input wire logic SPI_SCLK,
  input wire logic SPI_SDI,
  output logic SPI_SDO,
  output logic SPI_SDO_OE,
  // inputs from same-clock output logic
  input wire logic [NOUT-1:0] OUT_PD_REQ,
  input wire logic [NCH*8-1:0] FINE_CODE,
  input wire logic SYSREF_EVENT,
  // per-output enables
  output logic [NOUT-1:0] OUT_EN,
  // per-channel status and settings
  output logic [NCH-1:0] CH_RUN,
  output logic [NCH-1:0] CH_SYSREF_MODE,
  output logic [NCH-1:0] CH_EXT_BYPASS,
  output logic [NCH-1:0] CH_LOW_SUPPLY_AMP,
  output logic [NCH-1:0] FINE_CODE_BAD,
  output logic [NCH*DIV_W-1:0] CH_DIV_RATIO,
  output logic [NCH*DELAY_W-1:0] WIDE_DELAY_FS,
  output logic [NCH*DELAY_W-1:0] FINE_DELAY_FS,
  output logic [NCH*2-1:0] SYSREF_STATE
);

  // pin synchronisers
  logic cs_s1_r, cs_s2_r, sck_s1_r, sck_s2_r, sdi_s1_r, sdi_s2_r, sck_d_r;

  // select resets to idle so no frame opens while the pins settle
  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
    end else begin
      cs_s1_r <= SPI_CS_N;
      cs_s2_r <= cs_s1_r;
    end
  end

  // delayed copy starts at the idle low level, so reset gives no false rise
  always_ff @(posedge CLK) begin
    if (RST) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
    end else begin
      sck_s1_r <= SPI_SCLK;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
    end
  end

  // data shares the clock's latency, so each detected rise sees its own bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end else begin
      sdi_s1_r <= SPI_SDI;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  // serial frame handling
  logic [4:0] cnt_r;
  logic [6:0] shift_r;
  logic [7:0] out_sh_r;
  logic rd_r;
  logic [ADDR_W-1:0] addr_r;
  logic sdo_r, sdo_oe_r;

  wire sck_rise = sck_s2_r & ~sck_d_r;
  wire active = ~cs_s2_r;
  wire [7:0] frame_byte = {shift_r, sdi_s2_r};
  // bits past the sixteenth are ignored until select goes high
  wire bit_take = active & sck_rise & (cnt_r != FRAME_DONE);
  wire hdr_fire = active & sck_rise & (cnt_r == HDR_LAST);
  wire data_fire = active & sck_rise & (cnt_r == FRAME_LAST);
  wire wr_fire = data_fire & ~rd_r;
  wire [ADDR_W-1:0] hdr_addr = frame_byte[ADDR_W-1:0];
  wire hdr_rd = frame_byte[7];
  wire [ADDR_W-1:0] wr_addr = addr_r;
  wire wr_hit = wr_addr[6:5] == CH_BLOCK_TAG;
  wire [2:0] wr_ch = wr_addr[4:2];
  wire [1:0] wr_sub = wr_addr[1:0];
  wire [7:0] wr_data = frame_byte;

  // channel register storage
  logic [6:0] div_r [NCH];
  logic [8:0] wide_r [NCH];
  logic [NCH-1:0] pd_r, amp_r, retime_r, sel_r, bias_type_r, force_r, bypass_r;

  // read decode on the header address, loaded into the shifter at the header's end
  wire rd_hit = hdr_addr[6:5] == CH_BLOCK_TAG;
  wire [2:0] rd_ch = hdr_addr[4:2];
  wire [1:0] rd_sub = hdr_addr[1:0];
  wire [7:0] rd_ctrl = {pd_r[rd_ch], amp_r[rd_ch], retime_r[rd_ch], bypass_r[rd_ch],
                        2'h0, sel_r[rd_ch], wide_r[rd_ch][0]};
  wire [7:0] rd_bias = {6'h00, bias_type_r[rd_ch], force_r[rd_ch]};
  wire [7:0] rd_sel = (rd_sub == SUB_DIV) ? {1'b0, div_r[rd_ch]} :
                      (rd_sub == SUB_WIDE_HI) ? wide_r[rd_ch][8:1] :
                      (rd_sub == SUB_CTRL) ? rd_ctrl : rd_bias;
  // unmapped addresses read back as zero
  wire [7:0] rd_data = rd_hit ? rd_sel : 8'h00;

  // a frame cut short by select leaves no write behind
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_r <= 5'h00;
      shift_r <= 7'h00;
      rd_r <= 1'b0;
      addr_r <= '0;
    end else if (!active) begin
      cnt_r <= 5'h00;
      rd_r <= 1'b0;
    end else if (bit_take) begin
      cnt_r <= cnt_r + 5'h01;
      shift_r <= frame_byte[6:0];
      if (hdr_fire) begin
        rd_r <= hdr_rd;
        addr_r <= hdr_addr;
      end
    end
  end

  // read data is captured at the header's end, so a later write cannot tear it
  always_ff @(posedge CLK) begin
    if (RST) begin
      out_sh_r <= 8'h00;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (!active) begin
      sdo_oe_r <= 1'b0;
    end else if (hdr_fire) begin
      out_sh_r <= {rd_data[6:0], 1'b0};
      sdo_r <= rd_data[7];
      sdo_oe_r <= hdr_rd;
    end else if (data_fire) begin
      // release the line once the last data bit has been sampled
      sdo_oe_r <= 1'b0;
    end else if (bit_take && rd_r) begin
      sdo_r <= out_sh_r[7];
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
  end

  assign SPI_SDO = sdo_r;
  assign SPI_SDO_OE = sdo_oe_r;

  // per-channel registers and derived outputs
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    // C and D carry no bias controls but own the bypass select
    localparam bit IS_CD = (c == CH_C) || (c == CH_D);
    wire hit = wr_fire & wr_hit & (wr_ch == 3'(c));
    wire hit_div = hit & (wr_sub == SUB_DIV);
    wire hit_wide = hit & (wr_sub == SUB_WIDE_HI);
    wire hit_ctrl = hit & (wr_sub == SUB_CTRL);
    wire hit_bias = hit & (wr_sub == SUB_BIAS);

    always_ff @(posedge CLK) begin
      if (RST) begin
        div_r[c] <= DIV_RST;
      end else if (hit_div) begin
        div_r[c] <= wr_data[6:0];
      end
    end

    // the two halves land in separate frames: software sees a mixed code in between
    always_ff @(posedge CLK) begin
      if (RST) begin
        wide_r[c] <= WIDE_RST;
      end else if (hit_wide) begin
        wide_r[c][8:1] <= wr_data;
      end else if (hit_ctrl) begin
        wide_r[c][0] <= wr_data[B_WIDE0];
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        pd_r[c] <= 1'b0; // [R4]
      end else if (hit_ctrl) begin
        pd_r[c] <= wr_data[B_PD];
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        amp_r[c] <= 1'b0;
      end else if (hit_ctrl) begin
        amp_r[c] <= wr_data[B_AMP];
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        retime_r[c] <= 1'b0;
      end else if (hit_ctrl) begin
        retime_r[c] <= wr_data[B_RETIME];
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        sel_r[c] <= 1'b0;
      end else if (hit_ctrl) begin
        sel_r[c] <= wr_data[B_SEL];
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        bypass_r[c] <= 1'b0;
      end else if (hit_ctrl) begin
        bypass_r[c] <= IS_CD & wr_data[B_BYPASS]; // [R16]
      end
    end

    // C and D hold their bias bits at zero, so a read shows they are absent
    always_ff @(posedge CLK) begin
      if (RST) begin
        bias_type_r[c] <= IS_CD ? 1'b0 : BIAS_TYPE_RST; // [R13]
      end else if (hit_bias) begin
        bias_type_r[c] <= ~IS_CD & wr_data[B_BIAS_TYPE]; // [R15]
      end
    end

    always_ff @(posedge CLK) begin
      if (RST) begin
        force_r[c] <= 1'b0;
      end else if (hit_bias) begin
        force_r[c] <= ~IS_CD & wr_data[B_FORCE]; // [R15]
      end
    end

    // divider: stage one 1..5, stage two a power of two, stage one 000 skips stage two
    wire [2:0] st1_code = div_r[c][2:0];
    wire [3:0] st2_code = div_r[c][6:3];
    // reserved codes: stage one falls back to 1, stage two clamps to its largest legal setting
    wire [2:0] st1_val = (st1_code <= ST1_MAX_CODE) ? st1_code + 3'h1 : 3'h1;
    wire [3:0] st2_lim = (st2_code > ST2_MAX_CODE) ? ST2_MAX_CODE : st2_code;
    wire [3:0] st2_sh = (st1_code == ST1_BYPASS) ? 4'h0 : st2_lim; // [R17]
    wire [DIV_W-1:0] ratio_nxt = bypass_r[c] ? DIV_W'(1) : (DIV_W'(st1_val) << st2_sh); // [R16] [R17]

    // bypass skips the channel's divider and delay circuits
    wire idle = pd_r[c] | bypass_r[c];
    wire [DELAY_W-1:0] wide_nxt = idle ? '0 : DELAY_W'(wide_r[c]) * WIDE_STEP_FS; // [R1] [R2] [R4]

    // half steps only when a sysref channel asks for them
    wire half_step = sel_r[c] & retime_r[c]; // [R7]
    wire [DELAY_W-1:0] fine_step = half_step ? HALF_PERIOD_FS : OSC_PERIOD_FS; // [R9] [R11]
    wire [7:0] fine_code = FINE_CODE[c*8 +: 8];
    wire [DELAY_W-1:0] fine_nxt = idle ? '0 : DELAY_W'(fine_code) * fine_step;
    // codes 4n+2 and 4n+3 have no meaning with full steps
    wire bad_nxt = sel_r[c] & ~retime_r[c] & fine_code[1]; // [R10]

    ocd_state_t st_nxt;
    always_comb begin
      if (pd_r[c]) begin
        st_nxt = SR_LOW;
      end else if (!sel_r[c]) begin
        st_nxt = SR_CLOCK; // [R12]
      end else if (SYSREF_EVENT && !force_r[c]) begin
        st_nxt = SR_TOGGLE; // [R14]
      end else if (bias_type_r[c]) begin
        st_nxt = SR_CROSS; // [R13]
      end else begin
        st_nxt = SR_LOW; // [R13]
      end
    end

    // status flags, one cycle behind the stored settings
    always_ff @(posedge CLK) begin
      if (RST) begin
        CH_RUN[c] <= 1'b0;
        CH_SYSREF_MODE[c] <= 1'b0;
        CH_EXT_BYPASS[c] <= 1'b0;
        CH_LOW_SUPPLY_AMP[c] <= 1'b0;
        FINE_CODE_BAD[c] <= 1'b0;
      end else begin
        CH_RUN[c] <= ~pd_r[c]; // [R4]
        CH_SYSREF_MODE[c] <= sel_r[c]; // [R12]
        CH_EXT_BYPASS[c] <= bypass_r[c]; // [R16]
        CH_LOW_SUPPLY_AMP[c] <= amp_r[c];
        FINE_CODE_BAD[c] <= bad_nxt;
      end
    end

    // values registered so the products never reach the pins combinationally
    always_ff @(posedge CLK) begin
      if (RST) begin
        CH_DIV_RATIO[c*DIV_W +: DIV_W] <= '0;
        WIDE_DELAY_FS[c*DELAY_W +: DELAY_W] <= '0;
        FINE_DELAY_FS[c*DELAY_W +: DELAY_W] <= '0;
        SYSREF_STATE[c*2 +: 2] <= SR_LOW;
      end else begin
        CH_DIV_RATIO[c*DIV_W +: DIV_W] <= ratio_nxt;
        WIDE_DELAY_FS[c*DELAY_W +: DELAY_W] <= wide_nxt;
        FINE_DELAY_FS[c*DELAY_W +: DELAY_W] <= fine_nxt;
        SYSREF_STATE[c*2 +: 2] <= st_nxt;
      end
    end
  end

  // output enables: channel power-down wins over each output's own request
  for (genvar o = 0; o < NOUT; o++) begin : g_out
    always_ff @(posedge CLK) begin
      if (RST) begin
        OUT_EN[o] <= 1'b0;
      end else begin
        OUT_EN[o] <= ~pd_r[OUT_CH[o]] & ~OUT_PD_REQ[o]; // [R5]
      end
    end
  end

endmodule

// *** include/ocd_pkg.sv ***
// constants for the per-channel output delay / sysref control block
// assumes eight channels A..H with sixteen outputs behind them
package ocd_pkg;
  localparam int NCH_DEF = 8;
  localparam int NOUT_DEF = 16;
  localparam int DIV_W = 15;
  localparam int DELAY_W = 26;

  // serial frame: read flag, 7-bit address, 8-bit data, msb first
  localparam int ADDR_W = 7;
  localparam logic [4:0] HDR_LAST = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0F;
  localparam logic [4:0] FRAME_DONE = 5'h10;

  // channel block: four bytes per channel from the base
  localparam logic [1:0] CH_BLOCK_TAG = 2'h2;
  localparam logic [1:0] SUB_DIV = 2'h0;
  localparam logic [1:0] SUB_WIDE_HI = 2'h1;
  localparam logic [1:0] SUB_CTRL = 2'h2;
  localparam logic [1:0] SUB_BIAS = 2'h3;

  // bit positions in the control byte
  localparam int B_PD = 7;
  localparam int B_AMP = 6;
  localparam int B_RETIME = 5;
  localparam int B_BYPASS = 4;
  localparam int B_SEL = 1;
  localparam int B_WIDE0 = 0;
  // bit positions in the bias byte
  localparam int B_BIAS_TYPE = 1;
  localparam int B_FORCE = 0;

  // reset values
  localparam logic [6:0] DIV_RST = 7'h0B;
  localparam logic [8:0] WIDE_RST = 9'h000;
  localparam logic BIAS_TYPE_RST = 1'b1;

  // divider decode
  localparam logic [2:0] ST1_BYPASS = 3'h0;
  localparam logic [2:0] ST1_MAX_CODE = 3'h4;
  localparam logic [3:0] ST2_MAX_CODE = 4'hC;

  // step sizes in femtoseconds: internal oscillator period 254.314 ps
  localparam logic [DELAY_W-1:0] OSC_PERIOD_FS = 26'h003_E16A;
  localparam logic [DELAY_W-1:0] HALF_PERIOD_FS = OSC_PERIOD_FS >> 1;
  localparam logic [DELAY_W-1:0] WIDE_STEP_FS = HALF_PERIOD_FS;

  // channels that only carry the lvpecl outputs and the bypass path
  localparam int CH_C = 2;
  localparam int CH_D = 3;

  // per-channel output drive state
  typedef enum logic [1:0] {
    SR_LOW = 2'h0,
    SR_CROSS = 2'h1,
    SR_TOGGLE = 2'h2,
    SR_CLOCK = 2'h3
  } ocd_state_t;

  // owning channel of each output: A0 B0 B1 C0 C1 D0 D1 E0 E1 E2 F0 F1 G0 H0 H1 H2
  localparam int OUT_CH [NOUT_DEF] = '{0, 1, 1, 2, 2, 3, 3, 4, 4, 4, 5, 5, 6, 7, 7, 7};
endpackage

// *** bench/ocd_asserts.sv ***
// checker on the channel control ports
// assumes one clock domain, bound to every ocd_channel_ctrl
`timescale 1ns/1ps
module ocd_asserts
  import ocd_pkg::*;
#(
  parameter int NCH = NCH_DEF,
  parameter int NOUT = NOUT_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // block inputs
  input wire logic [NOUT-1:0] OUT_PD_REQ,
  input wire logic [NCH*8-1:0] FINE_CODE,
  input wire logic SYSREF_EVENT,
  // block outputs
  input wire logic [NOUT-1:0] OUT_EN,
  input wire logic [NCH-1:0] CH_RUN,
  input wire logic [NCH-1:0] CH_SYSREF_MODE,
  input wire logic [NCH-1:0] CH_EXT_BYPASS,
  input wire logic [NCH-1:0] FINE_CODE_BAD,
  input wire logic [NCH*DIV_W-1:0] CH_DIV_RATIO,
  input wire logic [NCH*DELAY_W-1:0] WIDE_DELAY_FS,
  input wire logic [NCH*2-1:0] SYSREF_STATE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  for (genvar i = 0; i < NOUT; i++) begin : g_out
    a_en_gate: assert property (!OUT_PD_REQ[i] |=> OUT_EN[i] == CH_RUN[OUT_CH[i]])
      else $error("output enable off its channel");
  end
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    wire logic [1:0] st = SYSREF_STATE[2*c+:2];
    wire logic [DIV_W-1:0] div = CH_DIV_RATIO[c*DIV_W+:DIV_W];
    wire logic [DELAY_W-1:0] wide = WIDE_DELAY_FS[c*DELAY_W+:DELAY_W];
    // settings held two cycles, so the registered outputs have caught up
    wire logic live = CH_RUN[c] && !CH_EXT_BYPASS[c];
    a_pd_quiet: assert property ((!CH_RUN[c]) [*2] |-> wide == 0 && st == SR_LOW)
      else $error("powered-down channel active");
    a_clk_state: assert property ((live && !CH_SYSREF_MODE[c]) [*2] |-> st == SR_CLOCK)
      else $error("clock channel state wrong");
    a_idle_static: assert property ((live && CH_SYSREF_MODE[c]) [*2] ##0 !$past(SYSREF_EVENT)
      |-> st != SR_TOGGLE)
      else $error("sysref toggles with no event");
    a_bad_code: assert property (FINE_CODE_BAD[c] |-> $past(FINE_CODE[8*c+1]))
      else $error("bad code flag without code bit");
    a_byp_path: assert property (CH_EXT_BYPASS[c] [*2] |-> div == 1 && wide == 0)
      else $error("bypass keeps divider or delay");
    a_div_range: assert property (!$past(RST) && !$past(RST, 2) |-> div inside {[1:20480]})
      else $error("divide ratio out of range");
  end
  a_byp_cd: assert property ((CH_EXT_BYPASS & ~NCH'(12)) == '0)
    else $error("bypass set outside C and D");
  c_pd: cover property (!CH_RUN[4]);
  c_toggle: cover property (SYSREF_STATE[11:10] == SR_TOGGLE);
  c_bypass: cover property (CH_EXT_BYPASS[2]);
endmodule

bind ocd_channel_ctrl ocd_asserts #(.NCH(NCH), .NOUT(NOUT)) i_asserts (
  .CLK(CLK), .RST(RST), .OUT_PD_REQ(OUT_PD_REQ), .FINE_CODE(FINE_CODE), .SYSREF_EVENT(SYSREF_EVENT),
  .OUT_EN(OUT_EN), .CH_RUN(CH_RUN), .CH_SYSREF_MODE(CH_SYSREF_MODE), .CH_EXT_BYPASS(CH_EXT_BYPASS),
  .FINE_CODE_BAD(FINE_CODE_BAD), .CH_DIV_RATIO(CH_DIV_RATIO), .WIDE_DELAY_FS(WIDE_DELAY_FS),
  .SYSREF_STATE(SYSREF_STATE));

// *** bench/ocd_host_model.sv ***
// serial host model driving configuration frames
// assumes the device samples these pins through synchronizers on clk
`timescale 1ns/1ps
module ocd_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // hp: sclk half period in clk cycles, 3 is the fastest allowed
  task automatic xfer(input logic [15:0] f, input int hp, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clk) cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      repeat (hp) @(negedge clk);
      if (i < 8) rd[i] = sdo_oe ? sdo : 1'bx;
      sclk = 1'b1;
      repeat (hp) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (hp) @(negedge clk);
    cs_n = 1'b1;
    // released line shows no stale level
    sdi = ~sdi;
    repeat (4) @(negedge clk);
  endtask
endmodule

// *** bench/test_output_channel_delay_sysref_control.sv ***
// bench: host model writes channel settings, outputs checked here
// assumes datapath inputs change at falling edges only
`timescale 1ns/1ps
module test_output_channel_delay_sysref_control;
  import ocd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ev = 1'b0;
  logic cs_n, sclk, sdi, sdo, oe;
  logic [15:0] req = '0;
  logic [63:0] fine = '0;
  logic [15:0] en, st;
  logic [7:0] run, srm, byp, amp, bad;
  logic [119:0] div;
  logic [207:0] wide, fdly;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  ocd_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(oe));
  ocd_channel_ctrl i_dut (.CLK(clk), .RST(rst), .SPI_CS_N(cs_n), .SPI_SCLK(sclk), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE(oe), .OUT_PD_REQ(req), .FINE_CODE(fine), .SYSREF_EVENT(ev),
    .OUT_EN(en), .CH_RUN(run), .CH_SYSREF_MODE(srm), .CH_EXT_BYPASS(byp), .CH_LOW_SUPPLY_AMP(amp),
    .FINE_CODE_BAD(bad), .CH_DIV_RATIO(div), .WIDE_DELAY_FS(wide), .FINE_DELAY_FS(fdly),
    .SYSREF_STATE(st));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic nap;
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [6:0] ad(input int c, input logic [1:0] s);
    return 7'(8'h40 + 4 * c + s);
  endfunction
  // reads use a slow sclk, writes the fastest one
  task automatic xf(input logic rdf, input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] rd;
    i_host.xfer({rdf, a, d}, rdf ? 6 : 3, rd);
    if (rdf) chk("read", e, rd);
  endtask
  task automatic t_reset;
    xf(1, ad(0, SUB_CTRL), 0, 8'h00);
    xf(1, ad(1, SUB_BIAS), 0, 8'h02);
    xf(1, ad(0, SUB_DIV), 0, 8'h0B);
    xf(1, 7'h10, 0, 8'h00);
    chk("run", 8'hFF, run);
    chk("div", 8, div[14:0]);
    chk("state", SR_CLOCK, st[1:0]);
  endtask
  task automatic t_wide;
    // wide stage stays on the internal oscillator, just under its 4 GHz input limit
    xf(0, ad(1, SUB_WIDE_HI), 8'hFF, 0);
    xf(0, ad(1, SUB_CTRL), 8'h01, 0);
    chk("wide max", 511 * WIDE_STEP_FS, wide[26+:26]);
    xf(0, ad(1, SUB_WIDE_HI), 8'h00, 0);
    chk("wide one", WIDE_STEP_FS, wide[26+:26]);
    xf(0, ad(1, SUB_CTRL), 8'h00, 0);
    chk("wide zero", 0, wide[26+:26]);
  endtask
  task automatic t_pd;
    xf(0, ad(4, SUB_WIDE_HI), 8'h01, 0);
    chk("wide pre", 2 * WIDE_STEP_FS, wide[104+:26]);
    xf(0, ad(4, SUB_CTRL), 8'h80, 0);
    chk("run pd", 0, run[4]);
    chk("wide pd", 0, wide[104+:26]);
    xf(1, ad(4, SUB_CTRL), 0, 8'h80);
    req = 16'h0001;
    nap();
    chk("en", 16'hFC7E, en);
    req = 16'h0000;
    xf(0, ad(4, SUB_CTRL), 8'h00, 0);
    chk("en up", 16'hFFFF, en);
    chk("wide back", 2 * WIDE_STEP_FS, wide[104+:26]);
  endtask
  task automatic t_sysref;
    xf(0, ad(5, SUB_CTRL), 8'h02, 0);
    chk("cross", SR_CROSS, st[11:10]);
    ev = 1'b1;
    nap();
    chk("toggle", SR_TOGGLE, st[11:10]);
    xf(0, ad(5, SUB_BIAS), 8'h01, 0);
    chk("static", SR_LOW, st[11:10]);
    ev = 1'b0;
  endtask
  task automatic t_fine;
    fine[47:40] = 8'h05;
    nap();
    chk("fine full", 5 * OSC_PERIOD_FS, fdly[130+:26]);
    fine[47:40] = 8'h02;
    nap();
    chk("bad", 8'h20, bad);
    xf(0, ad(5, SUB_CTRL), 8'h22, 0);
    chk("bad off", 0, bad);
    fine[47:40] = 8'hFF;
    nap();
    chk("fine half", 255 * HALF_PERIOD_FS, fdly[130+:26]);
    fine[55:48] = 8'h03;
    xf(0, ad(6, SUB_CTRL), 8'h20, 0);
    chk("fine clk", 3 * OSC_PERIOD_FS, fdly[156+:26]);
  endtask
  task automatic t_bypass;
    xf(0, ad(2, SUB_CTRL), 8'h10, 0);
    chk("byp", 8'h04, byp);
    chk("byp div", 1, div[30+:15]);
    xf(0, ad(0, SUB_CTRL), 8'h10, 0);
    xf(1, ad(0, SUB_CTRL), 0, 8'h00);
    xf(0, ad(2, SUB_BIAS), 8'h03, 0);
    xf(1, ad(2, SUB_BIAS), 0, 8'h00);
    xf(0, ad(2, SUB_CTRL), 8'h00, 0);
    chk("byp off", 8, div[30+:15]);
  endtask
  task automatic t_div_amp;
    xf(0, ad(3, SUB_DIV), 8'h00, 0);
    chk("div one", 1, div[45+:15]);
    xf(0, ad(3, SUB_DIV), 8'h64, 0);
    chk("div max", 32'h5000, div[45+:15]);
    xf(0, ad(7, SUB_CTRL), 8'h40, 0);
    chk("amp", 8'h80, amp);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    nap();
    t_reset();
    t_wide();
    t_pd();
    t_sysref();
    t_fine();
    t_bypass();
    t_div_amp();
    print_verdict();
  end
endmodule
